// ==== design/bstp_pkg.sv ====
package bstp_pkg;
	// tap controller states, standard binary encoding
	typedef enum logic [3:0] {
		BSTP_RESET      = 4'h0,
		BSTP_IDLE       = 4'h1,
		BSTP_SEL_DR     = 4'h2,
		BSTP_CAP_DR     = 4'h3,
		BSTP_SHIFT_DR   = 4'h4,
		BSTP_EXIT1_DR   = 4'h5,
		BSTP_PAUSE_DR   = 4'h6,
		BSTP_EXIT2_DR   = 4'h7,
		BSTP_UPD_DR     = 4'h8,
		BSTP_SEL_IR     = 4'h9,
		BSTP_CAP_IR     = 4'ha,
		BSTP_SHIFT_IR   = 4'hb,
		BSTP_EXIT1_IR   = 4'hc,
		BSTP_PAUSE_IR   = 4'hd,
		BSTP_EXIT2_IR   = 4'he,
		BSTP_UPD_IR     = 4'hf
	} bstp_state_t;

	localparam int          BSTP_IR_W     = 4;
	localparam int          BSTP_BSR_W    = 8;
	localparam int          BSTP_ID_W     = 32;
	// instruction codes
	localparam logic [3:0]  BSTP_INS_EXTEST  = 4'h0;
	localparam logic [3:0]  BSTP_INS_SAMPLE  = 4'h1;
	localparam logic [3:0]  BSTP_INS_IDCODE  = 4'h2;
	localparam logic [3:0]  BSTP_INS_BYPASS  = 4'hf;
	// capture pattern for the instruction register, low two bits fixed 01
	localparam logic [3:0]  BSTP_IR_CAPTURE  = 4'h1;
	localparam logic [3:0]  BSTP_IR_RESET    = BSTP_INS_IDCODE;
	// identity word: arbitrary value, lsb must be one
	localparam logic [31:0] BSTP_IDCODE      = 32'h1234_5679;
	localparam logic [7:0]  BSTP_BSR_RESET   = 8'h00;

	// one sampled set of link pins
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
	} bstp_pins_t;
endpackage

// ==== design/bstp_sync.sv ====
`timescale 1ns/100ps
// two-stage synchroniser for the link pins; the first stage feeds only the second
module bstp_sync
	import bstp_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire bstp_pins_t pins,
	output bstp_pins_t      pins_sync
);
	bstp_pins_t meta_q;

	// reset to idle-high pins, clock low
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q    <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
			pins_sync <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
		end else begin
			meta_q    <= pins;
			pins_sync <= meta_q;
		end
	end
endmodule

// ==== design/bstp_tap.sv ====
`timescale 1ns/100ps
// Behaviour
// [R1] behaves as a standard boundary-scan access port
// [R2] tdi captured on rising test clock
// [R3] tdo changes only on falling test clock; rst and low trst clear tdo and tdo_oe at any time
// [R4] tms sampled on rising edge advances controller
// [R5] test reset returns controller to reset
// [R6] open tdi, tms, trst read as high
// [R7] unused test clock held low externally
// [R8] sixteen-state controller, low trst forces reset
module bstp_tap
	import bstp_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire logic                  tck,
	input  wire logic                  tms,
	input  wire logic                  tms_oe,
	input  wire logic                  tdi,
	input  wire logic                  tdi_oe,
	input  wire logic                  trst_n,
	input  wire logic                  trst_n_oe,
	input  wire logic [BSTP_BSR_W-1:0] pins_in,
	output logic                       tdo,
	output logic                       tdo_oe,
	output logic [BSTP_BSR_W-1:0]      pins_out,
	output logic                       test_mode
);
	bstp_pins_t        raw;
	bstp_pins_t        pin_s;
	logic              tck_prev_q;
	logic              rise;
	logic              fall;
	bstp_state_t       state_q;
	bstp_state_t       state_d;
	logic [BSTP_IR_W-1:0]  ir_sh_q;
	logic [BSTP_IR_W-1:0]  ir_q;
	logic [BSTP_BSR_W-1:0] bsr_sh_q;
	logic [BSTP_ID_W-1:0]  id_sh_q;
	logic                  byp_q;
	logic                  serial_out;
	logic [BSTP_BSR_W-1:0] pins_meta_q;
	logic [BSTP_BSR_W-1:0] pins_s_q;

	// undriven tms, tdi and trst inputs read high, as a pull-up would make them
	// the pull-up sits ahead of the synchroniser, so a released pin reaches logic as a clean high
	assign raw.tck    = tck; // [R7]
	assign raw.tms    = tms_oe ? tms : 1'b1; // [R6]
	assign raw.tdi    = tdi_oe ? tdi : 1'b1; // [R6]
	assign raw.trst_n = trst_n_oe ? trst_n : 1'b1; // [R6]

	bstp_sync u_sync (
		.clock     (clock),
		.rst       (rst),
		.pins      (raw),
		.pins_sync (pin_s)
	);

	// edge finder on the sampled test clock
	always_ff @(posedge clock) begin
		if (rst) begin
			tck_prev_q <= 1'b0;
		end else begin
			tck_prev_q <= pin_s.tck;
		end
	end
	// each pulse lasts one clock, so the registers below move once per test clock edge
	assign rise = pin_s.tck & ~tck_prev_q;
	assign fall = ~pin_s.tck & tck_prev_q;

	// device pins come from another domain, so two flops before the boundary capture
	always_ff @(posedge clock) begin
		if (rst) begin
			pins_meta_q <= BSTP_BSR_RESET;
			pins_s_q    <= BSTP_BSR_RESET;
		end else begin
			pins_meta_q <= pins_in;
			pins_s_q    <= pins_meta_q;
		end
	end

	// instruction decode, shared by the extest flag, the pin latches and tdo
	function automatic logic is_scan(input logic [BSTP_IR_W-1:0] ins, input logic [3:0] code);
		is_scan = (ins == code);
	endfunction

	// shift states are the only ones in which tdo is driven
	function automatic logic in_shift(input bstp_state_t st);
		in_shift = (st == BSTP_SHIFT_DR) || (st == BSTP_SHIFT_IR);
	endfunction

	// next-state logic of the sixteen-state controller
	always_comb begin
		state_d = state_q;
		case (state_q)
			BSTP_RESET:    state_d = pin_s.tms ? BSTP_RESET : BSTP_IDLE;
			BSTP_IDLE:     state_d = pin_s.tms ? BSTP_SEL_DR : BSTP_IDLE;
			BSTP_SEL_DR:   state_d = pin_s.tms ? BSTP_SEL_IR : BSTP_CAP_DR;
			BSTP_CAP_DR:   state_d = pin_s.tms ? BSTP_EXIT1_DR : BSTP_SHIFT_DR;
			BSTP_SHIFT_DR: state_d = pin_s.tms ? BSTP_EXIT1_DR : BSTP_SHIFT_DR;
			BSTP_EXIT1_DR: state_d = pin_s.tms ? BSTP_UPD_DR : BSTP_PAUSE_DR;
			BSTP_PAUSE_DR: state_d = pin_s.tms ? BSTP_EXIT2_DR : BSTP_PAUSE_DR;
			BSTP_EXIT2_DR: state_d = pin_s.tms ? BSTP_UPD_DR : BSTP_SHIFT_DR;
			BSTP_UPD_DR:   state_d = pin_s.tms ? BSTP_SEL_DR : BSTP_IDLE;
			BSTP_SEL_IR:   state_d = pin_s.tms ? BSTP_RESET : BSTP_CAP_IR;
			BSTP_CAP_IR:   state_d = pin_s.tms ? BSTP_EXIT1_IR : BSTP_SHIFT_IR;
			BSTP_SHIFT_IR: state_d = pin_s.tms ? BSTP_EXIT1_IR : BSTP_SHIFT_IR;
			BSTP_EXIT1_IR: state_d = pin_s.tms ? BSTP_UPD_IR : BSTP_PAUSE_IR;
			BSTP_PAUSE_IR: state_d = pin_s.tms ? BSTP_EXIT2_IR : BSTP_PAUSE_IR;
			BSTP_EXIT2_IR: state_d = pin_s.tms ? BSTP_UPD_IR : BSTP_SHIFT_IR;
			BSTP_UPD_IR:   state_d = pin_s.tms ? BSTP_SEL_DR : BSTP_IDLE;
			default:       state_d = BSTP_RESET;
		endcase
	end

	// controller advances on sampled rising test clock; trst wins over everything
	// trst acts a few clocks after the pin falls; no test clock edge can slip in meanwhile
	always_ff @(posedge clock) begin
		if (rst || !pin_s.trst_n) begin
			state_q <= BSTP_RESET; // [R5] [R8]
		end else if (rise) begin
			state_q <= state_d; // [R4] [R8]
		end
	end

	// instruction shifter: capture pattern, then tdi moves in from the top
	always_ff @(posedge clock) begin
		if (rst || !pin_s.trst_n || state_q == BSTP_RESET) begin
			ir_sh_q <= BSTP_IR_RESET; // [R5]
		end else if (rise) begin
			if (state_q == BSTP_CAP_IR) begin
				ir_sh_q <= BSTP_IR_CAPTURE;
			end else if (state_q == BSTP_SHIFT_IR) begin
				ir_sh_q <= {pin_s.tdi, ir_sh_q[BSTP_IR_W-1:1]}; // [R2]
			end
		end
	end

	// active instruction; apart from reset loading idcode, only update-ir loads it, so a half-shifted code never acts
	always_ff @(posedge clock) begin
		if (rst || !pin_s.trst_n || state_q == BSTP_RESET) begin
			ir_q <= BSTP_IR_RESET; // [R5]
		end else if (rise && state_q == BSTP_UPD_IR) begin
			ir_q <= ir_sh_q; // [R1]
		end
	end

	// boundary shifter: captures the synchronised pin levels
	always_ff @(posedge clock) begin
		if (rst || !pin_s.trst_n) begin
			bsr_sh_q <= BSTP_BSR_RESET;
		end else if (rise) begin
			if (state_q == BSTP_CAP_DR) begin
				bsr_sh_q <= pins_s_q; // [R1]
			end else if (state_q == BSTP_SHIFT_DR) begin
				bsr_sh_q <= {pin_s.tdi, bsr_sh_q[BSTP_BSR_W-1:1]}; // [R2]
			end
		end
	end

	// identity shifter: reloads the fixed word on every capture
	always_ff @(posedge clock) begin
		if (rst || !pin_s.trst_n) begin
			id_sh_q <= BSTP_IDCODE;
		end else if (rise) begin
			if (state_q == BSTP_CAP_DR) begin
				id_sh_q <= BSTP_IDCODE;
			end else if (state_q == BSTP_SHIFT_DR) begin
				id_sh_q <= {pin_s.tdi, id_sh_q[BSTP_ID_W-1:1]}; // [R2]
			end
		end
	end

	// bypass bit: captures zero, then delays tdi by one test clock
	always_ff @(posedge clock) begin
		if (rst || !pin_s.trst_n) begin
			byp_q <= 1'b0;
		end else if (rise) begin
			if (state_q == BSTP_CAP_DR) begin
				byp_q <= 1'b0;
			end else if (state_q == BSTP_SHIFT_DR) begin
				byp_q <= pin_s.tdi; // [R2]
			end
		end
	end

	// extest flag; dropped in reset so the pins return to normal use at once
	always_ff @(posedge clock) begin
		if (rst || !pin_s.trst_n) begin
			test_mode <= 1'b0;
		end else begin
			test_mode <= is_scan(ir_q, BSTP_INS_EXTEST) && state_q != BSTP_RESET; // [R1]
		end
	end

	// boundary update latches take new pin values only while extest is loaded, and hold them otherwise until rst or trst clears them
	always_ff @(posedge clock) begin
		if (rst || !pin_s.trst_n) begin
			pins_out <= BSTP_BSR_RESET;
		end else if (rise && state_q == BSTP_UPD_DR && is_scan(ir_q, BSTP_INS_EXTEST)) begin
			pins_out <= bsr_sh_q; // [R1]
		end
	end

	// selected serial bit; unknown instructions fall to bypass
	always_comb begin
		serial_out = byp_q;
		if (state_q == BSTP_SHIFT_IR) begin
			serial_out = ir_sh_q[0];
		end else if (is_scan(ir_q, BSTP_INS_IDCODE)) begin
			serial_out = id_sh_q[0];
		end else if (is_scan(ir_q, BSTP_INS_EXTEST) || is_scan(ir_q, BSTP_INS_SAMPLE)) begin
			serial_out = bsr_sh_q[0];
		end
	end

	// output retimed on falling test clock so the tester samples a stable bit
	// the tester takes the bit at the next rise, so the synchroniser delay comes out of the low phase
	always_ff @(posedge clock) begin
		if (rst || !pin_s.trst_n) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (fall) begin
			tdo    <= serial_out; // [R3]
			tdo_oe <= in_shift(state_q); // [R3]
		end
	end
endmodule

// ==== tb/bstp_chk.sv ====
`timescale 1ns/100ps
// serial output timing and reset paths, seen from the pins
module bstp_chk
	import bstp_pkg::*;
(
	input wire logic                  clock,
	input wire logic                  rst,
	input wire logic                  tck,
	input wire logic                  trst_n,
	input wire logic                  trst_n_oe,
	input wire logic                  tdo,
	input wire logic                  tdo_oe,
	input wire logic [BSTP_BSR_W-1:0] pins_out,
	input wire logic                  test_mode
);
	wire trst_eff = trst_n || !trst_n_oe; // an open reset pin reads high
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_tdo_fall: assert property (disable iff (rst || !trst_eff)
		$changed(tdo) |-> !$past(tck, 2)) else $error("tdo moved off a fall");
	chk_oe_fall: assert property (disable iff (rst || !trst_eff)
		$changed(tdo_oe) |-> !$past(tck, 2)) else $error("tdo_oe moved off a fall");
	// six still samples outlast the input synchroniser
	chk_quiet_hold: assert property ($stable(tck) [*6] ##0 trst_eff
		|-> $stable({tdo, tdo_oe, pins_out, test_mode})) else $error("output moved, tck still");
	chk_trst_clears: assert property (!trst_eff [*6]
		|-> pins_out == BSTP_BSR_RESET && !test_mode) else $error("trst left pins set");
	chk_trst_quiet: assert property (!trst_eff [*6] |-> !tdo && !tdo_oe)
		else $error("trst left tdo driven");
	chk_rst_clears: assert property (disable iff (1'b0) rst [*2] |-> !tdo_oe && !test_mode)
		else $error("rst left port active");
	chk_pins_extest: assert property ($changed(pins_out)
		|-> $past(test_mode) || $past(test_mode, 2)) else $error("pins moved outside extest");
	cover property ($rose(tdo_oe));
	cover property ($rose(test_mode));
	cover property (!trst_eff [*6]);
endmodule
bind bstp_tap bstp_chk u_chk (.clock, .rst, .tck, .trst_n, .trst_n_oe, .tdo, .tdo_oe,
	.pins_out, .test_mode);

// ==== tb/bstp_ctl.sv ====
`timescale 1ns/100ps
// behavioural scan controller; tck rests low between bits
module bstp_ctl (
	output logic      tck,
	output logic      tms,
	output logic      tms_oe,
	output logic      tdi,
	output logic      tdi_oe,
	output logic      trst_n,
	output logic      trst_n_oe,
	input  wire logic tdo,
	input  wire logic tdo_oe
);
	initial {tck, tms, tdi, trst_n, tms_oe, tdi_oe, trst_n_oe} = 7'h3f;
	// long low phase so tdo has settled before it is taken at the rise
	task automatic step(input logic m, input logic v, output logic r);
		tms = m;
		tdi = v;
		// tdo has no pull, so a released pin reads as the inverse of its last bit
		#40 r = tdo_oe ? tdo : ~tdo;
		tck = 1'b1;
		#24 tck = 1'b0;
	endtask
	// walk np tms bits, shift n bits lsb first, then update and return to idle
	task automatic scan(input logic [3:0] p, input int np, input int n,
		input logic [31:0] din, output logic [31:0] dout);
		logic r;
		dout = 32'h0;
		for (int i = 0; i < np; i++) step(p[i], 1'b0, r);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], r);
			dout[i] = r;
		end
		step(1'b1, 1'b0, r);
		step(1'b0, 1'b0, r);
	endtask
endmodule

// ==== tb/boundary_scan_test_port_bench.sv ====
`timescale 1ns/100ps
module boundary_scan_test_port_bench
	import bstp_pkg::*;
;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  pins_in = 8'ha5;
	logic [7:0]  pins_out;
	logic        tck, tms, tms_oe, tdi, tdi_oe, trst_n, trst_n_oe, tdo, tdo_oe, test_mode, o;
	logic [31:0] d;
	int          fails = 0;
	int          total_checks = 0;
	always #4 clock = ~clock;
	bstp_ctl ctl (.tck, .tms, .tms_oe, .tdi, .tdi_oe, .trst_n, .trst_n_oe, .tdo, .tdo_oe);
	bstp_tap DUT (.clock, .rst, .tck, .tms, .tms_oe, .tdi, .tdi_oe, .trst_n, .trst_n_oe,
		.pins_in, .tdo, .tdo_oe, .pins_out, .test_mode);
	task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	// instruction capture, pin capture, then update drives the pins
	task automatic t_extest(input logic [7:0] v);
		ctl.scan(4'h3, 4, 4, 32'(BSTP_INS_EXTEST), d);
		check("ir", 32'(BSTP_IR_CAPTURE), d);
		ctl.scan(4'h1, 3, 8, 32'(v), d);
		check("bsr", 32'ha5, d);
		check("pins", 32'(v), 32'(pins_out));
		check("mode", 32'h1, 32'(test_mode));
	endtask
	// sample captures without driving the pins; bypass with open tdi shifts in ones
	task automatic t_bypass();
		ctl.scan(4'h3, 4, 4, 32'(BSTP_INS_SAMPLE), d);
		ctl.scan(4'h1, 3, 8, 32'h81, d);
		check("sample", 32'ha5, d);
		check("held", 32'h3c, 32'(pins_out));
		check("no mode", 32'h0, 32'(test_mode));
		ctl.scan(4'h3, 4, 4, 32'(BSTP_INS_BYPASS), d);
		ctl.tdi_oe = 1'b0;
		ctl.scan(4'h1, 3, 8, 32'h0, d);
		ctl.tdi_oe = 1'b1;
		check("bypass", 32'hfe, d);
	endtask
	// open tms is read high even when driven low behind the release
	task automatic t_float();
		{ctl.tms_oe, ctl.tdi_oe} = 2'b00;
		repeat (5) ctl.step(1'b0, 1'b0, o);
		{ctl.tms_oe, ctl.tdi_oe} = 2'b11;
		ctl.step(1'b0, 1'b0, o);
		check("float", 32'h0, 32'(test_mode));
	endtask
	// open reset pin reads high; driven low it drops extest and restores the identity
	task automatic t_trst();
		{ctl.trst_n, ctl.trst_n_oe} = 2'b00;
		#96 check("open trst", {23'h0, 8'hc3, 1'b1}, {23'h0, pins_out, test_mode});
		ctl.trst_n_oe = 1'b1;
		#96 ctl.trst_n = 1'b1;
		#64 check("trst", 32'h0, {pins_out, 22'h0, tdo_oe, test_mode});
		ctl.step(1'b0, 1'b0, o);
		ctl.scan(4'h1, 3, 32, 32'h0, d);
		check("id", BSTP_IDCODE, d);
	endtask
	task automatic print_verdict();
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clock);
		rst = 1'b0;
		#32 ctl.step(1'b0, 1'b0, o);
		t_extest(8'h3c);
		t_float();
		t_bypass();
		t_extest(8'hc3);
		t_trst();
		print_verdict();
	end
endmodule
